//--- logic/fsef_pkg.sv
package fsef_pkg;

  // bus geometry
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;

  // register indices and byte addresses (index times four)
  localparam logic [7:0]  IDX_CONFIG     = 8'h04;
  localparam logic [7:0]  IDX_ERR_CONFIG = 8'h05;
  localparam logic [7:0]  IDX_STATUS     = 8'h06;
  localparam logic [7:0]  IDX_ERR_STATUS = 8'h07;
  localparam logic [11:0] ADDR_CONFIG     = {2'h0, IDX_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_ERR_CONFIG = {2'h0, IDX_ERR_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_ERR_STATUS = {2'h0, IDX_ERR_STATUS, 2'h0};

  // flash_status_reg fields
  localparam int ST_DONE    = 7;
  localparam int ST_ACCESS_ERROR_FLAG  = 5;
  localparam int ST_PVIOL   = 4;
  localparam int ST_BUSY    = 3;
  localparam int ST_RESERVED_BIT    = 2;
  localparam int ST_CERR_LO = 0;

  // flash_error_status_reg fields
  localparam int ER_DOUBLE = 1;
  localparam int ER_SINGLE = 0;

  // flash_config_reg fields
  localparam int CF_DONE_IE = 7;
  localparam int CF_IGN_SF  = 4;

  // error configuration fields
  localparam int EC_DOUBLE_IE = 1;
  localparam int EC_SINGLE_IE = 0;

  // flag slots
  localparam int FL_DONE   = 0;
  localparam int FL_ACCESS_ERROR_FLAG = 1;
  localparam int FL_PVIOL  = 2;
  localparam int FL_DOUBLE = 3;
  localparam int FL_SINGLE = 4;
  localparam int NFLAG     = 5;

  // reset values
  localparam logic [4:0] FLAG_RST   = 5'h01;
  localparam logic [1:0] CERR_RST   = 2'h0;
  localparam logic [7:0] CONFIG_RST = 8'h00;

  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_ACK  = 1'b1
  } fsef_apb_e;

  // memory controller events, same clock
  typedef struct packed {
    logic       busy;
    logic       done;
    logic [1:0] err;
    logic       seq_viol;
    logic       illegal_cmd;
    logic       prot_viol;
    logic       rd_double;
    logic       rd_single;
    logic       rd_busy_block;
    logic       rst_done;
    logic       rst_double;
    logic [1:0] rst_err;
  } fsef_ctl_s;

  // outputs toward controller and interrupt logic
  typedef struct packed {
    logic cmd_launch;
    logic seq_allowed;
    logic irq_done;
    logic irq_double;
    logic irq_single;
  } fsef_out_s;

endpackage

//--- logic/fsef_flag.sv
`timescale 1ns/1ps
module fsef_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // events
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q
);

  logic q_next;

  // set wins over clear
  always_comb begin
    q_next = q;
    if (set) begin
      q_next = 1'b1;
    end else if (clr) begin
      q_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (ce) begin
      q <= q_next;
    end
  end

endmodule

//--- logic/fsef_top.sv
// Overview of operation
// - write one to done launches, clears it
// - sequence violation or illegal command sets access error
// - access error blocks command launch
// - write one clears access error
// - protected program or erase sets violation flag
// - write one clears violation flag
// - violation blocks launch and new sequence
// - busy flag mirrors memory controller state
// - reserved status bit reads zero
// - completion error field shows execution errors
// - only done, access, violation bits writable
// - reset-sequence double fault alters status
// - double fault or busy-block read sets flag
// - write one clears double-fault flag
// - single fault sets flag unless ignored
// - write one clears single-fault flag
// - error flags readable, writes only clear
// - done flag with enable requests interrupt
// - double fault with enable requests interrupt
// - single fault with enable requests interrupt
// - ignore mode suppresses single-fault reporting
`timescale 1ns/1ps
module fsef_top (
  // clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [fsef_pkg::ADDR_W-1:0] paddr,
  input  wire logic [fsef_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [fsef_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // memory controller
  input  wire fsef_pkg::fsef_ctl_s        ctl,
  output fsef_pkg::fsef_out_s             out
);

  // reset release
  logic [1:0]            rsync_reg;
  logic                  rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsync_reg <= 2'h0;
    end else if (clk_en) begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  // apb slave state
  fsef_pkg::fsef_apb_e   apb_reg;
  fsef_pkg::fsef_apb_e   apb_next;
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;
  logic                  pready_reg;
  logic                  pready_next;
  logic                  pslverr_reg;
  logic                  pslverr_next;
  logic                  mapped;
  logic [7:0]            rd_byte;
  logic                  wr_fire;
  logic                  w_st;
  logic                  w_er;
  logic                  w_cf;
  logic                  w_ec;
  logic [7:0]            wd;

  // software settings
  logic                  done_ie_reg;
  logic                  done_ie_next;
  logic                  ign_sf_reg;
  logic                  ign_sf_next;
  logic                  double_ie_reg;
  logic                  double_ie_next;
  logic                  single_ie_reg;
  logic                  single_ie_next;

  // status state
  logic [fsef_pkg::NFLAG-1:0] flag;
  logic [fsef_pkg::NFLAG-1:0] fset;
  logic [fsef_pkg::NFLAG-1:0] fclr;
  logic [1:0]            cerr_reg;
  logic [1:0]            cerr_next;
  logic                  busy_reg;
  logic                  busy_next;
  logic                  launch;
  fsef_pkg::fsef_out_s   out_reg;
  fsef_pkg::fsef_out_s   out_next;

  // address decode
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if (paddr == fsef_pkg::ADDR_CONFIG) begin
      rd_byte = 8'h00;
      rd_byte[fsef_pkg::CF_DONE_IE] = done_ie_reg;
      rd_byte[fsef_pkg::CF_IGN_SF]  = ign_sf_reg;
    end else if (paddr == fsef_pkg::ADDR_ERR_CONFIG) begin
      rd_byte = 8'h00;
      rd_byte[fsef_pkg::EC_DOUBLE_IE] = double_ie_reg;
      rd_byte[fsef_pkg::EC_SINGLE_IE] = single_ie_reg;
    end else if (paddr == fsef_pkg::ADDR_STATUS) begin
      rd_byte = 8'h00;
      rd_byte[fsef_pkg::ST_DONE]   = flag[fsef_pkg::FL_DONE];
      rd_byte[fsef_pkg::ST_ACCESS_ERROR_FLAG] = flag[fsef_pkg::FL_ACCESS_ERROR_FLAG];
      rd_byte[fsef_pkg::ST_PVIOL]  = flag[fsef_pkg::FL_PVIOL];
      rd_byte[fsef_pkg::ST_BUSY]   = busy_reg;
      rd_byte[fsef_pkg::ST_CERR_LO +: 2] = cerr_reg;
    end else if (paddr == fsef_pkg::ADDR_ERR_STATUS) begin
      rd_byte = 8'h00;
      rd_byte[fsef_pkg::ER_DOUBLE] = flag[fsef_pkg::FL_DOUBLE];
      rd_byte[fsef_pkg::ER_SINGLE] = flag[fsef_pkg::FL_SINGLE];
    end else begin
      mapped = 1'b0;
    end
  end

  // apb handshake, one wait state
  always_comb begin
    apb_next     = apb_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    case (apb_reg)
      fsef_pkg::APB_IDLE: begin
        if (psel && penable) begin
          apb_next     = fsef_pkg::APB_ACK;
          pready_next  = 1'b1;
          pslverr_next = ~mapped;
          prdata_next  = {24'h000000, pwrite ? 8'h00 : rd_byte};
        end
      end
      fsef_pkg::APB_ACK: begin
        apb_next = fsef_pkg::APB_IDLE;
      end
      default: begin
        apb_next = fsef_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      apb_reg     <= fsef_pkg::APB_IDLE;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      apb_reg     <= apb_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // write strobes, effect at the ready edge
  assign wr_fire = psel && penable && pready_reg && pwrite && pstrb[0] && mapped;
  assign wd      = pwdata[7:0];
  assign w_st    = wr_fire && (paddr == fsef_pkg::ADDR_STATUS);
  assign w_er    = wr_fire && (paddr == fsef_pkg::ADDR_ERR_STATUS);
  assign w_cf    = wr_fire && (paddr == fsef_pkg::ADDR_CONFIG);
  assign w_ec    = wr_fire && (paddr == fsef_pkg::ADDR_ERR_CONFIG);

  // configuration registers
  always_comb begin
    done_ie_next   = done_ie_reg;
    ign_sf_next    = ign_sf_reg;
    double_ie_next = double_ie_reg;
    single_ie_next = single_ie_reg;
    if (w_cf) begin
      done_ie_next = wd[fsef_pkg::CF_DONE_IE];
      ign_sf_next  = wd[fsef_pkg::CF_IGN_SF];
    end
    if (w_ec) begin
      double_ie_next = wd[fsef_pkg::EC_DOUBLE_IE];
      single_ie_next = wd[fsef_pkg::EC_SINGLE_IE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ie_reg   <= fsef_pkg::CONFIG_RST[fsef_pkg::CF_DONE_IE];
      ign_sf_reg    <= fsef_pkg::CONFIG_RST[fsef_pkg::CF_IGN_SF];
      double_ie_reg <= fsef_pkg::CONFIG_RST[fsef_pkg::EC_DOUBLE_IE];
      single_ie_reg <= fsef_pkg::CONFIG_RST[fsef_pkg::EC_SINGLE_IE];
    end else if (clk_en) begin
      done_ie_reg   <= done_ie_next;
      ign_sf_reg    <= ign_sf_next;
      double_ie_reg <= double_ie_next;
      single_ie_reg <= single_ie_next;
    end
  end

  // flag events
  always_comb begin
    launch = w_st && wd[fsef_pkg::ST_DONE] && flag[fsef_pkg::FL_DONE] &&
             !flag[fsef_pkg::FL_ACCESS_ERROR_FLAG] && !flag[fsef_pkg::FL_PVIOL];
    fset = '0;
    fclr = '0;
    fset[fsef_pkg::FL_DONE] = ctl.done || ctl.seq_viol || ctl.illegal_cmd || ctl.prot_viol;
    fclr[fsef_pkg::FL_DONE] = launch;
    fset[fsef_pkg::FL_ACCESS_ERROR_FLAG] = ctl.seq_viol || ctl.illegal_cmd;
    fclr[fsef_pkg::FL_ACCESS_ERROR_FLAG] = w_st && wd[fsef_pkg::ST_ACCESS_ERROR_FLAG];
    fset[fsef_pkg::FL_PVIOL] = ctl.prot_viol;
    fclr[fsef_pkg::FL_PVIOL] = w_st && wd[fsef_pkg::ST_PVIOL];
    fset[fsef_pkg::FL_DOUBLE] = ctl.rd_double || ctl.rd_busy_block;
    fclr[fsef_pkg::FL_DOUBLE] = w_er && wd[fsef_pkg::ER_DOUBLE];
    fset[fsef_pkg::FL_SINGLE] = !ign_sf_reg && (ctl.rd_single || ctl.rd_busy_block);
    fclr[fsef_pkg::FL_SINGLE] = w_er && wd[fsef_pkg::ER_SINGLE];
  end

  genvar gi;
  generate
    for (gi = 0; gi < fsef_pkg::NFLAG; gi++) begin : g_flag
      fsef_flag #(
        .RST_VAL (fsef_pkg::FLAG_RST[gi])
      ) u_flag (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (clk_en),
        .set   (fset[gi]),
        .clr   (fclr[gi]),
        .q     (flag[gi])
      );
    end
  endgenerate

  // controller status fields
  always_comb begin
    busy_next = ctl.busy;
    cerr_next = cerr_reg;
    // busy and error field ignore writes
    if (ctl.done) begin
      cerr_next = ctl.err;
    end else if (ctl.rst_done) begin
      cerr_next = ctl.rst_err | {ctl.rst_double, 1'b0};
    end else if (launch) begin
      cerr_next = fsef_pkg::CERR_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      cerr_reg <= fsef_pkg::CERR_RST;
    end else if (clk_en) begin
      busy_reg <= busy_next;
      cerr_reg <= cerr_next;
    end
  end

  // outputs
  always_comb begin
    out_next             = '0;
    out_next.cmd_launch  = launch;
    out_next.seq_allowed = !flag[fsef_pkg::FL_PVIOL];
    out_next.irq_done    = done_ie_reg && flag[fsef_pkg::FL_DONE];
    out_next.irq_double  = double_ie_reg && flag[fsef_pkg::FL_DOUBLE];
    out_next.irq_single  = single_ie_reg && flag[fsef_pkg::FL_SINGLE] && !ign_sf_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else if (clk_en) begin
      out_reg <= out_next;
    end
  end

  assign out = out_reg;

  // checks
  AST_LAUNCH_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && launch && !fset[fsef_pkg::FL_DONE] |=> !flag[fsef_pkg::FL_DONE] && out.cmd_launch)
    else $error("launch did not clear done flag");
  AST_ACCESS_ERROR_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && (ctl.seq_viol || ctl.illegal_cmd) |=> flag[fsef_pkg::FL_ACCESS_ERROR_FLAG] && flag[fsef_pkg::FL_DONE])
    else $error("access error not set");
  AST_ACCESS_ERROR_FLAG_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
    out.cmd_launch |-> !$past(flag[fsef_pkg::FL_ACCESS_ERROR_FLAG]))
    else $error("launch while access error set");
  AST_ACCESS_ERROR_FLAG_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && w_st && wd[fsef_pkg::ST_ACCESS_ERROR_FLAG] && !fset[fsef_pkg::FL_ACCESS_ERROR_FLAG] |=> !flag[fsef_pkg::FL_ACCESS_ERROR_FLAG])
    else $error("access error not cleared");
  AST_PVIOL_SET: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ctl.prot_viol |=> flag[fsef_pkg::FL_PVIOL] ##1 (!$past(clk_en) || !out.seq_allowed))
    else $error("violation flag not set");
  AST_PVIOL_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
    out.cmd_launch |-> !$past(flag[fsef_pkg::FL_PVIOL]))
    else $error("launch while violation set");
  AST_BUSY_MIRROR: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> busy_reg == $past(ctl.busy))
    else $error("busy flag does not follow controller");
  AST_RESERVED_BIT_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    pready && !pslverr |-> prdata[fsef_pkg::ST_RESERVED_BIT] == 1'b0 || $past(paddr) != fsef_pkg::ADDR_STATUS)
    else $error("reserved bit read nonzero");
  AST_DOUBLE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && (ctl.rd_double || ctl.rd_busy_block) |=> flag[fsef_pkg::FL_DOUBLE])
    else $error("double fault flag not set");
  AST_SINGLE_IGN: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ign_sf_reg && !flag[fsef_pkg::FL_SINGLE] |=> !flag[fsef_pkg::FL_SINGLE])
    else $error("single fault reported while ignored");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && fset[fsef_pkg::FL_SINGLE] && fclr[fsef_pkg::FL_SINGLE] |=> flag[fsef_pkg::FL_SINGLE])
    else $error("clear beat a set event");
  AST_DONE_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && done_ie_reg && flag[fsef_pkg::FL_DONE] |=> out.irq_done)
    else $error("done interrupt missing");

endmodule

//--- bench/fsef_ctl_model.sv
`timescale 1ns/1ps
module fsef_ctl_model #(
  parameter int DELAY = 12
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // from the block
  input  wire logic                cmd_launch,
  // bench control
  input  wire logic [1:0]          err_val,
  input  wire fsef_pkg::fsef_ctl_s inj,
  // toward the block
  output fsef_pkg::fsef_ctl_s      ctl
);
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  int   cnt_reg;
  int   cnt_next;

  // busy from launch until done pulse
  always_comb begin
    busy_next = busy_reg;
    done_next = 1'b0;
    cnt_next  = cnt_reg;
    if (cmd_launch && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next  = DELAY;
    end else if (busy_reg && cnt_reg == 0) begin
      busy_next = 1'b0;
      done_next = 1'b1;
    end else if (busy_reg) begin
      cnt_next = cnt_reg - 1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg  <= 0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg  <= cnt_next;
    end
  end

  // result code valid only with done
  always_comb begin
    ctl      = inj;
    ctl.busy = busy_reg;
    ctl.done = done_reg;
    ctl.err  = done_reg ? err_val : ~err_val;
  end
endmodule

//--- bench/fsef_top_test.sv
`timescale 1ns/1ps
module fsef_top_test;
  logic                clk;
  logic                nrst;
  logic                clk_en;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  fsef_pkg::fsef_ctl_s ctl;
  fsef_pkg::fsef_ctl_s inj;
  fsef_pkg::fsef_out_s out;
  logic [1:0]          err_val;
  int                  err_count;
  int                  cmp_count;
  int                  launch_cnt;
  int                  cyc;
  logic [32:0]         exp_q[$];
  logic [32:0]         mon_exp;
  logic [7:0]          rnd;
  logic [7:0]          cfg;
  logic [7:0]          bitv;

  fsef_top u_dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctl(ctl), .out(out));
  fsef_ctl_model u_model (.clk(clk), .nrst(nrst), .cmd_launch(out.cmd_launch), .err_val(err_val), .inj(inj),
    .ctl(ctl));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // answer monitor: oldest note against each completed transfer
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
      check({pslverr, prdata}, mon_exp);
    end
    if (out.cmd_launch === 1'b1) launch_cnt++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [32:0] exp);
    exp_q.push_back(exp);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 4'hF, {25'h0, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF, 33'h0);
  endtask

  task automatic pulse(input fsef_pkg::fsef_ctl_s e);
    inj <= e;
    @(posedge clk);
    inj <= '0;
    @(posedge clk);
  endtask

  function automatic fsef_pkg::fsef_ctl_s ev(input int k);
    ev = '0;
    case (k)
      0: ev.seq_viol = 1'b1;
      1: ev.illegal_cmd = 1'b1;
      2: ev.prot_viol = 1'b1;
      3: ev.rd_double = 1'b1;
      4: ev.rd_single = 1'b1;
      5: ev.rd_busy_block = 1'b1;
      default: begin
        ev.rst_done   = 1'b1;
        ev.rst_double = 1'b1;
        ev.rst_err    = 2'h1;
      end
    endcase
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    inj = '0;
    err_val = 2'h2;
    err_count = 0;
    cmp_count = 0;
    launch_cnt = 0;
    cyc = 0;
    rnd = 8'h42;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(fsef_pkg::ADDR_STATUS, 8'h80);
    rd(fsef_pkg::ADDR_ERR_STATUS, 8'h00);
    rd(fsef_pkg::ADDR_CONFIG, 8'h00);
    apb(1'b1, 12'h020, 8'hFF, 4'hF, 33'h1_0000_0000);
    pulse(ev(6));
    rd(fsef_pkg::ADDR_STATUS, 8'h83);
    cfg = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, fsef_pkg::ADDR_CONFIG, rnd, rnd[3:0], 33'h0);
      if (rnd[0]) cfg = rnd & 8'h90;
      rd(fsef_pkg::ADDR_CONFIG, cfg);
    end
    wr(fsef_pkg::ADDR_CONFIG, 8'h80);
    // interrupt output is one register behind the enable
    @(posedge clk);
    check({32'h0, out.irq_done}, 33'h1);
    wr(fsef_pkg::ADDR_STATUS, 8'h80);
    repeat (4) @(posedge clk);
    check({32'h0, out.irq_done}, 33'h0);
    check(launch_cnt, 1);
    rd(fsef_pkg::ADDR_STATUS, 8'h08);
    for (int n = 0; n < 100 && out.irq_done !== 1'b1; n++) @(posedge clk);
    rd(fsef_pkg::ADDR_STATUS, 8'h82);
    wr(fsef_pkg::ADDR_STATUS, 8'h0F);
    rd(fsef_pkg::ADDR_STATUS, 8'h82);
    for (int k = 0; k < 3; k++) begin
      bitv = (k < 2) ? 8'h20 : 8'h10;
      pulse(ev(k));
      rd(fsef_pkg::ADDR_STATUS, 8'h82 | bitv);
      check({32'h0, out.seq_allowed}, {32'h0, k < 2});
      wr(fsef_pkg::ADDR_STATUS, 8'h80);
      repeat (4) @(posedge clk);
      check(launch_cnt, 1);
      wr(fsef_pkg::ADDR_STATUS, 8'h00);
      rd(fsef_pkg::ADDR_STATUS, 8'h82 | bitv);
      wr(fsef_pkg::ADDR_STATUS, bitv);
      rd(fsef_pkg::ADDR_STATUS, 8'h82);
    end
    wr(fsef_pkg::ADDR_ERR_CONFIG, 8'h03);
    for (int k = 3; k < 6; k++) begin
      bitv = (k == 3) ? 8'h02 : (k == 4) ? 8'h01 : 8'h03;
      pulse(ev(k));
      @(posedge clk);
      check({31'h0, out.irq_double, out.irq_single}, {25'h0, bitv});
      rd(fsef_pkg::ADDR_ERR_STATUS, bitv);
      wr(fsef_pkg::ADDR_ERR_STATUS, 8'h00);
      rd(fsef_pkg::ADDR_ERR_STATUS, bitv);
      wr(fsef_pkg::ADDR_ERR_STATUS, 8'h03);
      rd(fsef_pkg::ADDR_ERR_STATUS, 8'h00);
    end
    wr(fsef_pkg::ADDR_CONFIG, 8'h90);
    pulse(ev(4));
    pulse(ev(5));
    check({32'h0, out.irq_single}, 33'h0);
    rd(fsef_pkg::ADDR_ERR_STATUS, 8'h02);
    fork
      wr(fsef_pkg::ADDR_ERR_STATUS, 8'h02);
      begin
        repeat (2) @(posedge clk);
        inj <= ev(3);
        @(posedge clk);
        inj <= '0;
      end
    join
    rd(fsef_pkg::ADDR_ERR_STATUS, 8'h02);
    wr(fsef_pkg::ADDR_ERR_STATUS, 8'h03);
    // fault event while the enable is low must be lost
    clk_en <= 1'b0;
    pulse(ev(3));
    clk_en <= 1'b1;
    rd(fsef_pkg::ADDR_ERR_STATUS, 8'h00);
    rd(fsef_pkg::ADDR_STATUS, 8'h82);
    give_verdict();
  end
endmodule
